// File: common/homing_pkg.sv
package homing_pkg;
   // apb register byte offsets
   localparam logic [7:0] ctrl_addr    = 8'h00;
   localparam logic [7:0] method_addr  = 8'h04;
   localparam logic [7:0] status_addr  = 8'h08;
   localparam logic [7:0] shift_addr   = 8'h0c;
   localparam logic [7:0] warning_addr = 8'h10;
   // control word fields
   localparam int ctrl_start_bit = 4;
   // status word fields
   localparam int stat_target_bit = 10;
   localparam int stat_homed_bit  = 12;
   localparam int stat_busy_bit   = 0;
   localparam int stat_warn_bit   = 1;
   localparam int stat_swlim_bit  = 2;
   localparam int stat_dir_bit    = 3;
   localparam int stat_run_bit    = 4;
   // warning code for an unfinished homing return
   localparam logic [7:0] homing_incomplete_warning = 8'h5a;
   localparam logic [7:0] method_reset = 8'h23;
   localparam logic [31:0] shift_reset = 32'h0000_0000;
   localparam logic [31:0] unmapped_data = 32'h0000_0000;

   typedef enum logic [2:0] {
      ref_last_index = 3'h0,  // dog front edge, index before dog end
      ref_cradle     = 3'h1,  // dog front edge, index after dog
      ref_dog_front  = 3'h2,  // home on dog front edge
      ref_dog_shift  = 3'h3,  // dog front edge plus shift distance
      ref_index_only = 3'h4,  // first index pulse, creep start
      ref_here       = 3'h5,  // current position
      ref_invalid    = 3'h6
   } ref_kind_t;

   typedef enum logic [2:0] {
      st_idle   = 3'h0,
      st_seek   = 3'h1,
      st_on_dog = 3'h2,
      st_index  = 3'h3,
      st_shift  = 3'h4,
      st_done   = 3'h5,
      st_fail   = 3'h6
   } state_t;
endpackage : homing_pkg

// File: common/method_if.sv
`timescale 1ns/100ps
interface method_if;
   logic [7:0]               method;
   homing_pkg::ref_kind_t    kind;
   logic                     reverse_start;
   logic                     stroke_reverses;

   modport decoder (input method, output kind, output reverse_start, output stroke_reverses);
   modport user (output method, input kind, input reverse_start, input stroke_reverses);
endinterface : method_if

// File: hdl/homing_method_decoder.sv
`timescale 1ns/100ps
module homing_method_decoder
(
   method_if.decoder   mi
);
   wire is_3_6   = (mi.method >= 8'h03) && (mi.method <= 8'h06);
   wire is_7_12  = (mi.method == 8'h07) || (mi.method == 8'h08) ||
                   (mi.method == 8'h0b) || (mi.method == 8'h0c);
   wire is_19_22 = (mi.method >= 8'h13) && (mi.method <= 8'h16);
   wire is_23_28 = (mi.method == 8'h17) || (mi.method == 8'h18) ||
                   (mi.method == 8'h1b) || (mi.method == 8'h1c);
   wire is_idx   = (mi.method == 8'h21) || (mi.method == 8'h22);
   wire is_here  = (mi.method == 8'h23) || (mi.method == 8'h25);
   // odd methods use last-index / front-edge, even ones cradle / shift
   wire even_m   = ~mi.method[0];

   // kind selection
   assign mi.kind = (is_3_6 || is_7_12)   ? (even_m ? homing_pkg::ref_cradle
                                                    : homing_pkg::ref_last_index) :
                    is_19_22              ? (even_m ? homing_pkg::ref_dog_shift
                                                    : homing_pkg::ref_dog_front) :
                    is_23_28              ? (even_m ? homing_pkg::ref_dog_shift
                                                    : homing_pkg::ref_dog_front) :
                    is_idx                ? homing_pkg::ref_index_only :
                    is_here               ? homing_pkg::ref_here :
                                            homing_pkg::ref_invalid;

   // reversed start: 5,6,11,12,21,22,27,28,33
   assign mi.reverse_start = (mi.method == 8'h05) || (mi.method == 8'h06) ||
                             (mi.method == 8'h0b) || (mi.method == 8'h0c) ||
                             (mi.method == 8'h15) || (mi.method == 8'h16) ||
                             (mi.method == 8'h1b) || (mi.method == 8'h1c) ||
                             (mi.method == 8'h21);

   // 7-12, 23-28 and 33-34 turn round at a stroke end, the others alarm
   assign mi.stroke_reverses = is_7_12 || is_23_28 || is_idx;
endmodule : homing_method_decoder

// File: hdl/homing_sequencer.sv
`timescale 1ns/100ps
// Functional notes
// - methods 3 to 6 reference the dog front edge and home on the index pulse next to the dog.
// - method 3 is the last-index dog return and method 4 the cradle return, both going forward.
// - in methods 3 to 6 a stroke end during homing aborts with the homing-incomplete warning.
// - methods 5 and 6 act as 3 and 4 but start in the reverse direction.
// - methods 7, 8, 11, 12 reach the same home as 3 to 6 but turn back at a stroke end.
// - method 7 is last-index, 8 is forward cradle, and 11 and 12 mirror them in reverse.
// - methods 19 to 22 and 23, 24, 27, 28 repeat 3 to 6 and 7, 8, 11, 12 but set home on the dog, not on an index pulse.
// - methods 23 and 27 home on the dog front edge, forward and reverse.
// - methods 24 and 28 home at the front edge plus the home shift distance.
// - methods 33 and 34 home on the first index pulse, starting at creep speed.
// - method 34 goes forward and method 33 goes in reverse.
// - methods 35 and 37 take the present position at once, even with the servo off.
// - methods 19 and 21 mirror each other, as do 20 and 22.
// - the software position limit is off while a stroke-reversing method runs.
// - warning code 90 means that the homing return did not complete.
module homing_sequencer
#(
   parameter int pos_w = 32
)
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   input  wire logic               index_pulse,
   input  wire logic               dog,
   input  wire logic               fwd_stroke_end,
   input  wire logic               rev_stroke_end,
   input  wire logic               servo_on,
   input  wire logic [pos_w-1:0]   position,
   output logic                    motion_request,
   output logic                    motion_reverse,
   output logic                    creep_speed,
   output logic                    soft_limit_enable,
   output logic                    home_set,
   output logic [pos_w-1:0]        home_position
);
   method_if mi ();

   logic [31:0]            ctrl;
   logic [7:0]             method;
   logic [31:0]            shift_dist;
   logic [7:0]             warning;
   logic                   target_reached;
   logic                   homing_attained;
   logic                   dir_rev;
   logic                   reversed_once;
   logic                   dog_d;
   logic                   idx_d;
   logic                   start_d;
   logic [pos_w-1:0]       front_pos;
   homing_pkg::state_t     state;
   homing_pkg::state_t     next_state;

   homing_method_decoder u_dec (.mi(mi.decoder));
   assign mi.method = method;

   // bus decode
   wire acc       = psel && penable;
   wire wr        = acc && pwrite;
   wire sel_ctrl  = (paddr == homing_pkg::ctrl_addr);
   wire sel_meth  = (paddr == homing_pkg::method_addr);
   wire sel_stat  = (paddr == homing_pkg::status_addr);
   wire sel_shift = (paddr == homing_pkg::shift_addr);
   wire sel_warn  = (paddr == homing_pkg::warning_addr);
   wire mapped    = sel_ctrl || sel_meth || sel_stat || sel_shift || sel_warn;

   wire busy = (state != homing_pkg::st_idle) && (state != homing_pkg::st_done) &&
               (state != homing_pkg::st_fail);

   logic [31:0] status_word;
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[homing_pkg::stat_target_bit] = target_reached;
      status_word[homing_pkg::stat_homed_bit]  = homing_attained;
      status_word[homing_pkg::stat_busy_bit]   = busy;
      status_word[homing_pkg::stat_warn_bit]   = (warning != 8'h00);
      status_word[homing_pkg::stat_swlim_bit]  = soft_limit_enable;
      status_word[homing_pkg::stat_dir_bit]    = dir_rev;
      status_word[homing_pkg::stat_run_bit]    = motion_request;
   end

   wire [31:0] rd_mux = sel_ctrl  ? ctrl :
                        sel_meth  ? {24'h00_0000, method} :
                        sel_stat  ? status_word :
                        sel_shift ? shift_dist :
                        sel_warn  ? {24'h00_0000, warning} :
                                    homing_pkg::unmapped_data;

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   always_ff @(posedge clk)
   begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_mux;
   end

   // method may change only while not busy, so a running sequence is stable
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl       <= 32'h0000_0000;
         method     <= homing_pkg::method_reset;
         shift_dist <= homing_pkg::shift_reset;
      end
      else if (wr)
      begin
         if (sel_ctrl)
            ctrl <= pwdata;
         if (sel_meth && !busy)
            method <= pwdata[7:0];
         if (sel_shift)
            shift_dist <= pwdata;
      end
   end

   wire start_bit  = ctrl[homing_pkg::ctrl_start_bit];
   wire start_rise = start_bit && !start_d;
   wire dog_front  = dog && !dog_d;
   wire dog_rear   = !dog && dog_d;
   wire idx_rise   = index_pulse && !idx_d;
   wire stroke_hit = dir_rev ? rev_stroke_end : fwd_stroke_end;
   wire stroke_rev = mi.stroke_reverses;
   wire here_kind  = (mi.kind == homing_pkg::ref_here);
   wire [pos_w-1:0] travelled = dir_rev ? (front_pos - position) : (position - front_pos);
   wire shift_met  = (travelled >= shift_dist[pos_w-1:0]);
   wire may_start  = servo_on || here_kind;

   always_comb
   begin
      next_state = state;
      case (state)
         homing_pkg::st_idle, homing_pkg::st_done, homing_pkg::st_fail:
            if (start_rise && mi.kind != homing_pkg::ref_invalid && may_start)
            begin
               if (here_kind)
                  next_state = homing_pkg::st_done;
               else if (mi.kind == homing_pkg::ref_index_only)
                  next_state = homing_pkg::st_index;
               else
                  next_state = homing_pkg::st_seek;
            end
            else if (start_rise)
               next_state = homing_pkg::st_fail;
         homing_pkg::st_seek:
            if (stroke_hit && !stroke_rev)
               next_state = homing_pkg::st_fail;
            else if (dog_front)
            begin
               if (mi.kind == homing_pkg::ref_dog_front)
                  next_state = homing_pkg::st_done;
               else if (mi.kind == homing_pkg::ref_dog_shift)
                  next_state = homing_pkg::st_shift;
               else
                  next_state = homing_pkg::st_on_dog;
            end
         homing_pkg::st_on_dog:
            if (stroke_hit && !stroke_rev)
               next_state = homing_pkg::st_fail;
            else if (mi.kind == homing_pkg::ref_last_index && idx_rise)
               next_state = homing_pkg::st_done;
            else if (mi.kind == homing_pkg::ref_cradle && dog_rear)
               next_state = homing_pkg::st_index;
            else if (mi.kind == homing_pkg::ref_last_index && dog_rear)
               next_state = homing_pkg::st_fail;
         homing_pkg::st_index:
            if (stroke_hit && !stroke_rev)
               next_state = homing_pkg::st_fail;
            else if (idx_rise)
               next_state = homing_pkg::st_done;
         homing_pkg::st_shift:
            if (stroke_hit && !stroke_rev)
               next_state = homing_pkg::st_fail;
            else if (shift_met)
               next_state = homing_pkg::st_done;
         default:
            next_state = homing_pkg::st_idle;
      endcase
      // dropping the start bit or the servo stops a moving sequence
      if (busy && (!start_bit || !servo_on))
         next_state = homing_pkg::st_fail;
   end

   wire begin_run  = !busy && (next_state != homing_pkg::st_idle) &&
                     (next_state != homing_pkg::st_done) && (next_state != homing_pkg::st_fail);
   // a fresh current-position start re-homes even from the done state
   wire enter_done = (next_state == homing_pkg::st_done) &&
                     ((state != homing_pkg::st_done) || start_rise);
   wire enter_fail = (next_state == homing_pkg::st_fail) && (state != homing_pkg::st_fail);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state   <= homing_pkg::st_idle;
         dog_d   <= 1'b0;
         idx_d   <= 1'b0;
         start_d <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         dog_d   <= dog;
         idx_d   <= index_pulse;
         start_d <= start_bit;
      end
   end

   // direction: start side from the method, flip once at a stroke end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dir_rev       <= 1'b0;
         reversed_once <= 1'b0;
      end
      else if (begin_run)
      begin
         dir_rev       <= mi.reverse_start;
         reversed_once <= 1'b0;
      end
      else if (busy && stroke_hit && stroke_rev && !reversed_once)
      begin
         dir_rev       <= !dir_rev;
         reversed_once <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         front_pos <= '0;
      else if (state == homing_pkg::st_seek && dog_front)
         front_pos <= position;
   end

   // completion flags; a new start clears them on the same edge as the run begins
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         target_reached  <= 1'b0;
         homing_attained <= 1'b0;
         warning         <= 8'h00;
         home_set        <= 1'b0;
         home_position   <= '0;
      end
      else
      begin
         home_set <= enter_done;
         if (enter_done)
         begin
            target_reached  <= 1'b1;
            homing_attained <= 1'b1;
            home_position   <= position;
            warning         <= 8'h00;
         end
         else if (enter_fail)
         begin
            target_reached  <= 1'b1;
            homing_attained <= 1'b0;
            warning         <= homing_pkg::homing_incomplete_warning;
         end
         else if (begin_run)
         begin
            target_reached  <= 1'b0;
            homing_attained <= 1'b0;
            warning         <= 8'h00;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         motion_request    <= 1'b0;
         motion_reverse    <= 1'b0;
         creep_speed       <= 1'b0;
         soft_limit_enable <= 1'b1;
      end
      else
      begin
         motion_request    <= busy;
         motion_reverse    <= dir_rev;
         // creep from the start for index-only, after the dog otherwise
         creep_speed       <= busy && (state != homing_pkg::st_seek);
         soft_limit_enable <= !(busy && stroke_rev);
      end
   end
endmodule : homing_sequencer

// File: testbench/homing_sequencer_sva.sv
`timescale 1ns/100ps
module homing_sequencer_sva
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        fwd_stroke_end,
   input wire logic        rev_stroke_end,
   input wire logic        motion_request,
   input wire logic        motion_reverse,
   input wire logic        creep_speed,
   input wire logic        soft_limit_enable,
   input wire logic        home_set
);
   logic [7:0] meth;
   logic       start_q;
   logic       arm;
   wire wr_acc = psel && penable && pwrite;
   wire ctrl_wr = wr_acc && paddr == homing_pkg::ctrl_addr;
   wire go = ctrl_wr && pwdata[homing_pkg::ctrl_start_bit] && !start_q;
   wire fwd_m = meth inside {8'h03, 8'h04, 8'h07, 8'h08, 8'h13, 8'h14, 8'h17, 8'h18, 8'h22};
   wire rev_m = meth inside {8'h05, 8'h06, 8'h0b, 8'h0c, 8'h15, 8'h16, 8'h1b, 8'h1c, 8'h21};
   wire turn_m = meth inside {8'h07, 8'h08, 8'h0b, 8'h0c, 8'h17, 8'h18, 8'h1b, 8'h1c, 8'h21, 8'h22};
   wire fail_m = meth inside {[8'h03:8'h06], [8'h13:8'h16]};
   wire here_m = meth inside {8'h23, 8'h25};
   wire stroke = motion_reverse ? rev_stroke_end : fwd_stroke_end;
   // arm marks the first cycle of motion_request after a start, before any turn at a stroke end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meth <= homing_pkg::method_reset;
         start_q <= 1'b0;
         arm <= 1'b0;
      end
      else
      begin
         if (wr_acc && paddr == homing_pkg::method_addr)
            meth <= pwdata[7:0];
         if (ctrl_wr)
            start_q <= pwdata[homing_pkg::ctrl_start_bit];
         arm <= go ? 1'b1 : (motion_request ? 1'b0 : arm);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_pulse; home_set |=> !home_set ##1 !motion_request; endproperty
   a_pulse: assert property (p_pulse)
      else $error("home_set wider than one cycle");
   property p_here; go && here_m |-> (!motion_request throughout ##[1:4] home_set); endproperty
   a_here: assert property (p_here)
      else $error("current position homing moved or did not finish");
   property p_soft; motion_request && turn_m |-> !soft_limit_enable; endproperty
   a_soft: assert property (p_soft)
      else $error("soft limit on during reversing method");
   property p_fwd; arm && motion_request && fwd_m |-> !motion_reverse; endproperty
   a_fwd: assert property (p_fwd)
      else $error("forward method started in reverse");
   property p_rev; arm && motion_request && rev_m |-> motion_reverse; endproperty
   a_rev: assert property (p_rev)
      else $error("reverse method started forward");
   property p_fail; motion_request && fail_m && stroke |-> ##[1:6] !motion_request; endproperty
   a_fail: assert property (p_fail)
      else $error("no abort at stroke end");
   property p_turn;
      motion_request && turn_m && stroke && !motion_reverse |-> ##[1:6] motion_reverse;
   endproperty
   a_turn: assert property (p_turn)
      else $error("no reversal at stroke end");
   property p_creep; arm && motion_request && meth inside {8'h21, 8'h22} |-> creep_speed; endproperty
   a_creep: assert property (p_creep)
      else $error("index homing not started at creep");
   c_here: cover property (go && here_m);
   c_turn: cover property (motion_request && turn_m && stroke);
   c_fail: cover property (motion_request && fail_m && stroke);
   c_home: cover property (home_set);
endmodule : homing_sequencer_sva

// File: testbench/axis_model.sv
`timescale 1ns/100ps
module axis_model
(
   input  wire logic               clk,
   input  wire logic               load,
   input  wire logic signed [31:0] start_pos,
   input  wire logic signed [31:0] dog_lo,
   input  wire logic signed [31:0] dog_hi,
   input  wire logic signed [31:0] lim_hi,
   input  wire logic signed [31:0] lim_lo,
   input  wire logic               motion_request,
   input  wire logic               motion_reverse,
   output logic signed [31:0]      pos,
   output logic                    dog,
   output logic                    index_pulse,
   output logic                    fwd_stroke_end,
   output logic                    rev_stroke_end
);
   logic [2:0] tick;
   // one step per eight clocks so every sensor edge outlasts the input sync
   always_ff @(posedge clk)
   begin
      tick <= load ? 3'h0 : tick + 3'h1;
      if (load)
         pos <= start_pos;
      else if (motion_request && tick == 3'h7)
         pos <= motion_reverse ? pos - 1 : pos + 1;
   end
   assign dog = pos >= dog_lo && pos <= dog_hi;
   assign index_pulse = pos[3:0] == 4'h0;
   assign fwd_stroke_end = pos >= lim_hi;
   assign rev_stroke_end = pos <= lim_lo;
endmodule : axis_model

// File: testbench/test_servo_homing_method_sequencer.sv
`timescale 1ns/100ps
module test_servo_homing_method_sequencer;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0;
   logic               servo_on = 1'b0;
   logic               load = 1'b0;
   logic signed [31:0] sp = 0, dlo = 0, dhi = 0, lhi = 0, llo = 0;
   logic signed [31:0] position;
   logic [31:0]        prdata, home_position, q, rng = 32'h0000_7857;
   logic               pready, pslverr, motion_request, motion_reverse, creep_speed;
   logic               soft_limit_enable, home_set, index_pulse, dog, fse, rse;
   logic [64:0]        rd_q[$], e_rd;
   logic [63:0]        home_q[$], e_hm;
   int                 err_count = 0, cmp_count = 0, cycles = 0;
   homing_sequencer i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .index_pulse(index_pulse), .dog(dog), .fwd_stroke_end(fse),
      .rev_stroke_end(rse), .servo_on(servo_on), .position(position),
      .motion_request(motion_request), .motion_reverse(motion_reverse),
      .creep_speed(creep_speed), .soft_limit_enable(soft_limit_enable),
      .home_set(home_set), .home_position(home_position));
   axis_model i_axis (.clk(clk), .load(load), .start_pos(sp), .dog_lo(dlo), .dog_hi(dhi),
      .lim_hi(lhi), .lim_lo(llo), .motion_request(motion_request),
      .motion_reverse(motion_reverse), .pos(position), .dog(dog),
      .index_pulse(index_pulse), .fwd_stroke_end(fse), .rev_stroke_end(rse));
   always #4 clk = ~clk;
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xorshift
   task check(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // a read carries {slave error, compare mask, data} of what it expects
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         rd_q.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task run(input logic [7:0] m, input int s, lo, hi, lh, ll, input logic sv, ok, ab,
            input logic [31:0] hm, hv);
      int n;
      @(posedge clk);
      {sp, dlo, dhi, lhi, llo, servo_on, load} <= {s, lo, hi, lh, ll, sv, 1'b1};
      @(posedge clk);
      load <= 1'b0;
      apb(1'b1, homing_pkg::method_addr, {24'h0, m}, 65'h0);
      apb(1'b1, homing_pkg::ctrl_addr, 32'h1 << homing_pkg::ctrl_start_bit, 65'h0);
      if (ok)
         home_q.push_back({hm, hv});
      repeat (4) @(posedge clk);
      if (ab)
         apb(1'b1, homing_pkg::ctrl_addr, 32'h0, 65'h0);
      n = 0;
      do
      begin
         apb(1'b0, homing_pkg::status_addr, 32'h0, 65'h0);
         n++;
      end
      while (q[homing_pkg::stat_busy_bit] !== 1'b0 && n < 3000);
      apb(1'b0, homing_pkg::status_addr, 32'h0,
          {33'h0_0000_1403, ok ? 32'h0000_1400 : 32'h0000_0402});
      apb(1'b0, homing_pkg::warning_addr, 32'h0,
          {33'h0_ffff_ffff, ok ? 24'h0 : 24'h0, ok ? 8'h00 : homing_pkg::homing_incomplete_warning});
      check(home_q.size(), 0);
      apb(1'b1, homing_pkg::ctrl_addr, 32'h0, 65'h0);
      $display("test method %0d over", m);
   endtask : run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_count++;
         print_verdict();
      end
      if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      begin
         e_rd = rd_q.pop_front();
         check({pslverr, prdata & e_rd[63:32]}, {e_rd[64], e_rd[31:0]});
      end
      if (home_set === 1'b1)
      begin
         if (home_q.size() == 0)
            check(33'h1_0000_0000, 33'h0);
         else
         begin
            e_hm = home_q.pop_front();
            check({1'b0, home_position & e_hm[63:32]}, {1'b0, e_hm[31:0]});
         end
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, homing_pkg::method_addr, 32'h0, {33'h0_ffff_ffff, 24'h0, homing_pkg::method_reset});
      apb(1'b0, homing_pkg::status_addr, 32'h0, {33'h0_0000_1407, 32'h0000_0004});
      apb(1'b0, homing_pkg::shift_addr, 32'h0, {33'h0_ffff_ffff, homing_pkg::shift_reset});
      apb(1'b0, 8'h14, 32'h0, {33'h1_ffff_ffff, homing_pkg::unmapped_data});
      rng = xorshift(rng);
      run(8'h23, rng[15:0], 200, 210, 900, -900, 1'b0, 1, 0, '1, rng[15:0]);
      run(8'h25, 5, 200, 210, 900, -900, 1'b1, 1, 0, '1, 5);
      run(8'h17, 5, 20, 30, 100, -100, 1'b1, 1, 0, '1, 20);
      run(8'h1b, 5, -40, -30, 100, -100, 1'b1, 1, 0, '1, -30);
      rng = xorshift(rng);
      apb(1'b1, homing_pkg::shift_addr, {28'h0, rng[3:0]}, 65'h0);
      run(8'h18, 5, 20, 30, 100, -100, 1'b1, 1, 0, '1, 20 + rng[3:0]);
      run(8'h1c, 5, -40, -30, 100, -100, 1'b1, 1, 0, 0, 0);
      run(8'h22, 5, 200, 210, 900, -900, 1'b1, 1, 0, '1, 16);
      run(8'h21, 5, 200, 210, 900, -900, 1'b1, 1, 0, '1, 0);
      run(8'h03, 5, 20, 40, 100, -100, 1'b1, 1, 0, '1, 32);
      run(8'h04, 5, 20, 30, 100, -100, 1'b1, 1, 0, '1, 32);
      run(8'h05, 5, -40, -30, 100, -100, 1'b1, 1, 0, '1, -32);
      run(8'h06, 5, -40, -30, 100, -100, 1'b1, 1, 0, '1, -48);
      run(8'h03, 5, 200, 210, 12, -100, 1'b1, 0, 0, 0, 0);
      run(8'h07, 5, -40, -30, 12, -100, 1'b1, 1, 0, '1, -32);
      run(8'h0c, 5, 20, 30, 100, -12, 1'b1, 1, 0, '1, 32);
      run(8'h13, 5, 20, 30, 100, -100, 1'b1, 1, 0, '1, 20);
      run(8'h15, 5, -40, -30, 100, -100, 1'b1, 1, 0, '1, -30);
      run(8'h14, 5, 200, 210, 12, -100, 1'b1, 0, 0, 0, 0);
      run(8'h11, 5, 20, 30, 100, -100, 1'b1, 0, 0, 0, 0);
      run(8'h17, 5, 20, 30, 100, -100, 1'b0, 0, 0, 0, 0);
      run(8'h17, 5, 200, 210, 900, -900, 1'b1, 0, 1, 0, 0);
      print_verdict();
   end
endmodule : test_servo_homing_method_sequencer
bind homing_sequencer homing_sequencer_sva i_sva (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .fwd_stroke_end(fwd_stroke_end), .rev_stroke_end(rev_stroke_end),
   .motion_request(motion_request), .motion_reverse(motion_reverse),
   .creep_speed(creep_speed), .soft_limit_enable(soft_limit_enable), .home_set(home_set));
